// ### common/rot_ret_pkg.sv
// Constants shared by the return and rotate execution slice.
package rot_ret_pkg;
   // Register map byte offsets on the register bus.
   localparam logic [7:0] OFS_WORK = 8'h00;
   localparam logic [7:0] OFS_FLAGS = 8'h04;
   localparam logic [7:0] OFS_BANK = 8'h08;
   localparam logic [7:0] OFS_WORK_SH = 8'h0c;
   localparam logic [7:0] OFS_FLAGS_SH = 8'h10;
   localparam logic [7:0] OFS_BANK_SH = 8'h14;
   localparam logic [7:0] OFS_IRQ_CTRL = 8'h18;
   localparam logic [7:0] OFS_PC_LATCH = 8'h1c;
   localparam logic [7:0] OFS_STATE = 8'h20;
   // Flag register bit positions.
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 4;
   // Interrupt control bit positions.
   localparam int IRQ_HIGH = 0;
   localparam int IRQ_LOW = 1;
   localparam int EXT_SET = 2;
   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_BANK = 4'h0;
   // Opcode patterns (upper bits compared).
   localparam logic [14:0] OPC_IRQ_EXIT = 15'h0008;
   localparam logic [14:0] OPC_SUB_EXIT = 15'h0009;
   localparam logic [7:0] OPC_LIT_EXIT = 8'h0c;
   localparam logic [5:0] OPC_ROT_LC = 6'h0d;
   localparam logic [5:0] OPC_ROT_LP = 6'h11;
   localparam logic [5:0] OPC_ROT_RC = 6'h0c;
   // Addressing constants.
   localparam logic [7:0] INDEXED_MAX = 8'h5f;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Sequencer states.
   typedef enum logic [0:0] {
      ST_EXEC = 1'b0,
      ST_SECOND = 1'b1
   } seq_state_t;
endpackage

// ### rtl/return_and_rotate_exec.sv
// Execution slice for the three return and three rotate instructions.
// Contract
// - Interrupt exit pops the stack into the program counter and sets one global irq enable, in two cycles.
// - Interrupt exit with the fast bit set restores working, flags and bank select from shadows, else leaves them.
// - Interrupt exit and literal exit leave the upper and high program counter latches unchanged.
// - Literal exit loads the literal into working and pops the stack into the program counter, in two cycles.
// - Subroutine exit pops the stack into the program counter in two cycles, the second doing nothing.
// - Subroutine exit with the fast bit set restores working, flags and bank select from shadows.
// - Rotate left through carry moves bit 7 to carry, old carry to bit 0, and updates C, N and Z.
// - Rotate right through carry moves bit 0 to carry, old carry to bit 7, and updates C, N and Z.
// - A destination bit of 0 sends a rotate result to working, 1 back to the file register.
// - An operand bank bit of 0 addresses the access bank, 1 uses the bank select register.
// - With the extended set on, bank bit 0 and address at most 95, the operand is indexed.
`timescale 1ns/1ns
`default_nettype none
module return_and_rotate_exec
   import rot_ret_pkg::*;
(
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Instruction issue.
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   output logic o_instr_ready,
   // Return stack and program counter.
   input wire logic [20:0] i_stack_top,
   output logic o_stack_pop,
   output logic o_pc_load,
   output logic [20:0] o_pc,
   // File register port and indexed base.
   input wire logic [11:0] i_index_base,
   input wire logic [7:0] i_file_rdata,
   output logic [11:0] o_file_addr,
   output logic o_file_we,
   output logic [11:0] o_file_waddr,
   output logic [7:0] o_file_wdata,
   // AXI4-Lite write channels.
   input wire logic i_awvalid,
   input wire logic [7:0] i_awaddr,
   output logic o_awready,
   input wire logic i_wvalid,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_wready,
   output logic o_bvalid,
   output logic [1:0] o_bresp,
   input wire logic i_bready,
   // AXI4-Lite read channels.
   input wire logic i_arvalid,
   input wire logic [7:0] i_araddr,
   output logic o_arready,
   output logic o_rvalid,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   input wire logic i_rready
);
////////////////////////////////////////////////////////////////////////////
   logic [7:0] work, flags, work_sh, flags_sh, aw_addr;
   logic [3:0] bank, bank_sh, w_strb;
   logic [2:0] irq_ctrl;
   logic [12:0] pc_latch;
   seq_state_t state;
   logic [2:0] last_op;
   // Issue and opcode decode.
   wire issue = i_instr_valid && o_instr_ready;
   wire fast = i_instr[0];
   wire is_irq_exit = issue && (i_instr[15:1] == OPC_IRQ_EXIT);
   wire is_sub_exit = issue && (i_instr[15:1] == OPC_SUB_EXIT);
   wire is_lit_exit = issue && (i_instr[15:8] == OPC_LIT_EXIT);
   wire is_rot_lc = issue && (i_instr[15:10] == OPC_ROT_LC);
   wire is_rot_lp = issue && (i_instr[15:10] == OPC_ROT_LP);
   wire is_rot_rc = issue && (i_instr[15:10] == OPC_ROT_RC);
   wire is_ret = is_irq_exit || is_sub_exit || is_lit_exit;
   wire is_rot = is_rot_lc || is_rot_lp || is_rot_rc;
   wire restore = (is_irq_exit || is_sub_exit) && fast;
   wire dest_file = i_instr[9];
   wire bank_bit = i_instr[8];
   wire [7:0] faddr = i_instr[7:0];
   // Operand address; indexed mode adds the literal offset to the base.
   wire indexed = irq_ctrl[EXT_SET] && !bank_bit && (faddr <= INDEXED_MAX);
   wire [11:0] access_addr = (faddr <= INDEXED_MAX) ?
      {ACCESS_LO_BANK, faddr} : {ACCESS_HI_BANK, faddr};
   wire [11:0] bank_addr = {bank, faddr};
   wire [11:0] index_addr = i_index_base + {4'h0, faddr};
   assign o_file_addr = indexed ? index_addr :
      (bank_bit ? bank_addr : access_addr);
   // Forward a pending write so back-to-back rotates see fresh data.
   wire fwd = o_file_we && (o_file_waddr == o_file_addr);
   wire [7:0] operand = fwd ? o_file_wdata : i_file_rdata;
   // Rotate datapath.
   wire old_c = flags[FLAG_C];
   wire [7:0] rot_res = is_rot_rc ? {old_c, operand[7:1]} :
      (is_rot_lc ? {operand[6:0], old_c} :
      {operand[6:0], operand[7]});
   wire rot_c = is_rot_rc ? operand[0] : operand[7];
   wire upd_c = is_rot_lc || is_rot_rc;
   // Register bus decode.
   logic aw_held, w_held;
   logic [31:0] w_data;
   wire sw_wr = aw_held && w_held && !o_bvalid;
   wire wr_work = sw_wr && (aw_addr == OFS_WORK) && w_strb[0];
   wire wr_flags = sw_wr && (aw_addr == OFS_FLAGS) && w_strb[0];
   wire wr_bank = sw_wr && (aw_addr == OFS_BANK) && w_strb[0];
   wire wr_work_sh = sw_wr && (aw_addr == OFS_WORK_SH) && w_strb[0];
   wire wr_flags_sh = sw_wr && (aw_addr == OFS_FLAGS_SH) && w_strb[0];
   wire wr_bank_sh = sw_wr && (aw_addr == OFS_BANK_SH) && w_strb[0];
   wire wr_irq = sw_wr && (aw_addr == OFS_IRQ_CTRL) && w_strb[0];
   wire wr_lat_lo = sw_wr && (aw_addr == OFS_PC_LATCH) && w_strb[0];
   wire wr_lat_hi = sw_wr && (aw_addr == OFS_PC_LATCH) && w_strb[1];
   wire wr_map = (aw_addr <= OFS_PC_LATCH) && (aw_addr[1:0] == 2'b00);
   wire rd_map = (i_araddr <= OFS_STATE) && (i_araddr[1:0] == 2'b00);
   wire [31:0] rd_mux =
      (i_araddr == OFS_WORK) ? {24'h000000, work} :
      (i_araddr == OFS_FLAGS) ? {24'h000000, flags} :
      (i_araddr == OFS_BANK) ? {28'h0000000, bank} :
      (i_araddr == OFS_WORK_SH) ? {24'h000000, work_sh} :
      (i_araddr == OFS_FLAGS_SH) ? {24'h000000, flags_sh} :
      (i_araddr == OFS_BANK_SH) ? {28'h0000000, bank_sh} :
      (i_araddr == OFS_IRQ_CTRL) ? {29'h00000000, irq_ctrl} :
      (i_araddr == OFS_PC_LATCH) ? {19'h00000, pc_latch} :
      (i_araddr == OFS_STATE) ? {28'h0000000, last_op, state} :
      32'h00000000;
   // Instructions take priority over a software write in the same cycle.
   wire [7:0] next_work = restore ? work_sh :
      is_lit_exit ? i_instr[7:0] :
      (is_rot && !dest_file) ? rot_res :
      wr_work ? w_data[7:0] : work;
   wire [7:0] rot_flags = {flags[7:5], rot_res[7], flags[3],
      (rot_res == 8'h00), flags[1], upd_c ? rot_c : old_c};
   wire [7:0] next_flags = restore ? flags_sh :
      is_rot ? rot_flags :
      wr_flags ? w_data[7:0] : flags;
   wire [3:0] next_bank = restore ? bank_sh :
      wr_bank ? w_data[3:0] : bank;
   // Set the high enable if it is off, otherwise the low enable.
   wire [2:0] irq_set = irq_ctrl[IRQ_HIGH] ? 3'b010 : 3'b001;
   wire [2:0] next_irq = is_irq_exit ? (irq_ctrl | irq_set) :
      wr_irq ? w_data[2:0] : irq_ctrl;
////////////////////////////////////////////////////////////////////////////
   // Two-cycle returns hold issue off for their idle second cycle.
   assign o_instr_ready = (state == ST_EXEC);
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state <= ST_EXEC;
      end else begin
         case (state)
            ST_EXEC: state <= is_ret ? ST_SECOND : ST_EXEC;
            ST_SECOND: state <= ST_EXEC;
            default: state <= ST_EXEC;
         endcase
      end
   end
   // Core register updates.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         work <= RST_BYTE;
         flags <= RST_BYTE;
         bank <= RST_BANK;
         irq_ctrl <= 3'h0;
         last_op <= 3'h0;
      end else begin
         work <= next_work;
         flags <= next_flags;
         bank <= next_bank;
         irq_ctrl <= next_irq;
         if (is_ret || is_rot) begin
            last_op <= {is_rot, is_lit_exit || is_rot_lp,
               is_sub_exit || is_rot_rc};
         end
      end
   end
   // Shadows and latches; returns never touch the latches.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         work_sh <= RST_BYTE;
         flags_sh <= RST_BYTE;
         bank_sh <= RST_BANK;
         pc_latch <= 13'h0000;
      end else begin
         if (wr_work_sh) work_sh <= w_data[7:0];
         if (wr_flags_sh) flags_sh <= w_data[7:0];
         if (wr_bank_sh) bank_sh <= w_data[3:0];
         if (wr_lat_lo) pc_latch[7:0] <= w_data[7:0];
         if (wr_lat_hi) pc_latch[12:8] <= w_data[12:8];
      end
   end
   // Stack pop, program counter load and file write are registered.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_stack_pop <= 1'b0;
         o_pc_load <= 1'b0;
         o_pc <= 21'h000000;
         o_file_we <= 1'b0;
         o_file_waddr <= 12'h000;
         o_file_wdata <= 8'h00;
      end else begin
         o_stack_pop <= is_ret;
         o_pc_load <= is_ret;
         if (is_ret) o_pc <= i_stack_top;
         o_file_we <= is_rot && dest_file;
         if (is_rot) begin
            o_file_waddr <= o_file_addr;
            o_file_wdata <= rot_res;
         end
      end
   end
////////////////////////////////////////////////////////////////////////////
   // Write address and data are taken in either order, then answered.
   assign o_awready = !aw_held && !o_bvalid;
   assign o_wready = !w_held && !o_bvalid;
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
         if (sw_wr) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end
   // Reads answer one cycle after the address is taken.
   assign o_arready = !o_rvalid;
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rdata <= rd_mux;
         o_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end
////////////////////////////////////////////////////////////////////////////
   // Checks on the slice's own behaviour.
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_two_cycles;
      o_stack_pop && !o_instr_ready ##1 o_instr_ready;
   endsequence
   property p_irq_exit_pc;
      is_irq_exit |=> o_pc_load && (o_pc == $past(i_stack_top));
   endproperty
   a_irq_exit_pc: assert property (p_irq_exit_pc)
      else $error("interrupt exit did not load the stack top");
   property p_irq_en;
      is_irq_exit |=> (irq_ctrl[IRQ_HIGH] || irq_ctrl[IRQ_LOW]);
   endproperty
   a_irq_en: assert property (p_irq_en)
      else $error("interrupt exit left both enables clear");
   property p_restore;
      restore |=> work == $past(work_sh) && flags == $past(flags_sh)
         && bank == $past(bank_sh);
   endproperty
   a_restore: assert property (p_restore)
      else $error("fast return did not restore the shadows");
   property p_no_restore;
      (is_irq_exit || is_sub_exit) && !fast |=> $stable(work)
         && $stable(bank);
   endproperty
   a_no_restore: assert property (p_no_restore)
      else $error("plain return changed working or bank");
   property p_latch_kept;
      (is_irq_exit || is_lit_exit) && !sw_wr |=> $stable(pc_latch);
   endproperty
   a_latch_kept: assert property (p_latch_kept)
      else $error("return changed a program counter latch");
   property p_lit;
      is_lit_exit |=> work == $past(i_instr[7:0]);
   endproperty
   a_lit: assert property (p_lit)
      else $error("literal exit did not load working");
   property p_two_cycle;
      is_ret |=> s_two_cycles;
   endproperty
   a_two_cycle: assert property (p_two_cycle)
      else $error("return did not take exactly two cycles");
   property p_rlc;
      is_rot_lc |=> flags[FLAG_C] == $past(operand[7]);
   endproperty
   a_rlc: assert property (p_rlc)
      else $error("left carry rotate wrong carry");
   property p_rlp;
      is_rot_lp |=> flags[FLAG_C] == $past(flags[FLAG_C]);
   endproperty
   a_rlp: assert property (p_rlp)
      else $error("plain rotate changed carry");
   property p_rrc;
      is_rot_rc |=> flags[FLAG_C] == $past(operand[0]);
   endproperty
   a_rrc: assert property (p_rrc)
      else $error("right carry rotate wrong carry");
   property p_dest;
      is_rot |=> o_file_we == $past(dest_file);
   endproperty
   a_dest: assert property (p_dest)
      else $error("rotate destination wrong");
   property p_bank;
      issue && bank_bit |-> o_file_addr[11:8] == bank;
   endproperty
   a_bank: assert property (p_bank)
      else $error("banked operand not addressed by bank select");
   property p_index;
      issue && irq_ctrl[EXT_SET] && !bank_bit && (faddr <= INDEXED_MAX) |->
         o_file_addr == i_index_base + {4'h0, faddr};
   endproperty
   a_index: assert property (p_index)
      else $error("indexed operand address wrong");
   property p_rot_one;
      is_rot |-> o_instr_ready ##1 o_instr_ready;
   endproperty
   a_rot_one: assert property (p_rot_one)
      else $error("rotate stalled issue");
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the return and rotate execution slice.
`timescale 1ns/1ns
`default_nettype none
module testbench
   import rot_ret_pkg::*;
;
   ////////////////////////////////////////////////////////////////////////
   logic i_sys_clk, i_rst_n, i_instr_valid, o_instr_ready;
   logic [15:0] i_instr;
   logic [20:0] i_stack_top, o_pc;
   logic o_stack_pop, o_pc_load, o_file_we;
   logic [11:0] i_index_base, o_file_addr, o_file_waddr, last_addr;
   logic [7:0] i_file_rdata, o_file_wdata, i_awaddr, i_araddr;
   logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
   logic i_arvalid, o_arready, o_rvalid, i_rready;
   logic [31:0] i_wdata, o_rdata, rd_data;
   logic [3:0] i_wstrb;
   logic [1:0] o_bresp, o_rresp, rd_resp;
   int miscompares = 0;
   int total_checks = 0;

   return_and_rotate_exec i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .o_instr_ready(o_instr_ready), .i_stack_top(i_stack_top),
      .o_stack_pop(o_stack_pop), .o_pc_load(o_pc_load), .o_pc(o_pc),
      .i_index_base(i_index_base), .i_file_rdata(i_file_rdata),
      .o_file_addr(o_file_addr), .o_file_we(o_file_we),
      .o_file_waddr(o_file_waddr), .o_file_wdata(o_file_wdata),
      .i_awvalid(i_awvalid), .i_awaddr(i_awaddr), .o_awready(o_awready),
      .i_wvalid(i_wvalid), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
      .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
      .i_bready(i_bready), .i_arvalid(i_arvalid), .i_araddr(i_araddr),
      .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
      .o_rresp(o_rresp), .i_rready(i_rready));

   // Free-running 250 MHz clock.
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Verdict and comparison helpers.
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d.", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // A wait that runs out is a failure; the run stops so it cannot hang.
   task automatic timeout();
      miscompares++;
      $display("MISMATCH wait_limit expected 1 seen 0");
      finish_test();
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Register bus master: address and data offered together.
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
      int n;
      @(posedge i_sys_clk);
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_awaddr <= ad;
      i_wdata <= dt;
      i_bready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge i_sys_clk);
         if (o_bvalid) break;
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      end
      i_bready <= 1'b0;
      if (n == 20) timeout();
      chk("bresp", 32'(o_bresp), 32'(RESP_OKAY));
   endtask

   task automatic rd(input logic [7:0] ad);
      int n;
      @(posedge i_sys_clk);
      i_arvalid <= 1'b1;
      i_araddr <= ad;
      i_rready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge i_sys_clk);
         if (o_rvalid) break;
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      end
      i_rready <= 1'b0;
      if (n == 20) timeout();
      rd_data = o_rdata;
      rd_resp = o_rresp;
   endtask

   task automatic rchk(input string nm, input logic [7:0] ad,
                       input logic [31:0] exp);
      rd(ad);
      chk(nm, rd_data, exp);
      chk("rresp", 32'(rd_resp), 32'(RESP_OKAY));
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Issue one opcode and wait until it is taken; outputs settle after #1.
   task automatic exec(input logic [15:0] ins, input logic [20:0] top,
                       input logic [7:0] fd);
      int n;
      @(posedge i_sys_clk);
      i_instr_valid <= 1'b1;
      i_instr <= ins;
      i_stack_top <= top;
      i_file_rdata <= fd;
      for (n = 0; n < 20; n++) begin
         @(posedge i_sys_clk);
         if (o_instr_ready) break;
      end
      last_addr = o_file_addr;
      i_instr_valid <= 1'b0;
      if (n == 20) timeout();
      #1;
   endtask

   // A return pops once, loads the stack top and blocks one more cycle.
   task automatic ret_case(input logic [15:0] ins, input logic [20:0] top);
      exec(ins, top, 8'h00);
      chk("stack_pop", 32'(o_stack_pop), 32'h1);
      chk("pc_load", 32'(o_pc_load), 32'h1);
      chk("pc", 32'(o_pc), 32'(top));
      chk("instr_ready", 32'(o_instr_ready), 32'h0);
   endtask

   // Rotate with the expected result worked out here from the shift rules.
   task automatic rot_case(input logic [5:0] op, input logic d, a,
      input logic [7:0] f, fd, input logic cin, input logic [11:0] ea);
      logic [7:0] res;
      logic cout;
      wr(OFS_FLAGS, {31'h0, cin});
      if (op == OPC_ROT_LC)
         {cout, res} = {fd, cin};
      else if (op == OPC_ROT_RC)
         {res, cout} = {cin, fd};
      else
         {cout, res} = {cin, fd[6:0], fd[7]};
      exec({op, d, a, f}, 21'h0, fd);
      chk("file_addr", 32'(last_addr), 32'(ea));
      chk("file_we", 32'(o_file_we), 32'(d));
      if (d) begin
         chk("file_waddr", 32'(o_file_waddr), 32'(ea));
         chk("file_wdata", 32'(o_file_wdata), 32'(res));
      end else begin
         rchk("work", OFS_WORK, 32'(res));
      end
      rchk("flags", OFS_FLAGS, {27'h0, res[7], 1'b0, res == 8'h00, 1'b0,
         cout});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      {i_instr_valid, i_awvalid, i_wvalid, i_bready} = 4'h0;
      {i_arvalid, i_rready, i_rst_n} = 3'h0;
      i_instr = 16'h0000;
      i_stack_top = 21'h0;
      i_index_base = 12'h000;
      i_file_rdata = 8'h00;
      i_awaddr = 8'h00;
      i_araddr = 8'h00;
      i_wdata = 32'h0;
      i_wstrb = 4'hf;
      repeat (5) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      rchk("work", OFS_WORK, 32'h0);
      rchk("irq_ctrl", OFS_IRQ_CTRL, 32'h0);
      rd(8'h40);
      chk("unmapped_resp", 32'(rd_resp), 32'(RESP_SLVERR));
      wr(OFS_WORK_SH, 32'ha5);
      wr(OFS_FLAGS_SH, 32'h15);
      wr(OFS_BANK_SH, 32'h3);
      wr(OFS_PC_LATCH, 32'h1234);
      ret_case(16'h0010, 21'h012345);
      rchk("work", OFS_WORK, 32'h0);
      rchk("irq_ctrl", OFS_IRQ_CTRL, 32'h1);
      ret_case(16'h0011, 21'h0abcde);
      rchk("irq_ctrl", OFS_IRQ_CTRL, 32'h3);
      rchk("work", OFS_WORK, 32'ha5);
      rchk("flags", OFS_FLAGS, 32'h15);
      rchk("bank", OFS_BANK, 32'h3);
      rchk("pc_latch", OFS_PC_LATCH, 32'h1234);
      ret_case(16'h0c5a, 21'h000100);
      rchk("work", OFS_WORK, 32'h5a);
      rchk("pc_latch", OFS_PC_LATCH, 32'h1234);
      ret_case(16'h0012, 21'h1fffff);
      rchk("work", OFS_WORK, 32'h5a);
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_BANK, 32'h0);
      ret_case(16'h0013, 21'h000002);
      rchk("work", OFS_WORK, 32'ha5);
      rchk("flags", OFS_FLAGS, 32'h15);
      rchk("bank", OFS_BANK, 32'h3);
      rot_case(OPC_ROT_LC, 1, 1, 8'h22, 8'h80, 0, 12'h322);
      rot_case(OPC_ROT_LC, 0, 0, 8'h60, 8'h41, 1, 12'hf60);
      rot_case(OPC_ROT_LP, 1, 0, 8'h5f, 8'h81, 1, 12'h05f);
      rot_case(OPC_ROT_LP, 0, 1, 8'h01, 8'h00, 0, 12'h301);
      rot_case(OPC_ROT_RC, 1, 0, 8'hff, 8'h01, 0, 12'hfff);
      rot_case(OPC_ROT_RC, 0, 1, 8'h10, 8'h02, 1, 12'h310);
      wr(OFS_IRQ_CTRL, 32'h4);
      i_index_base <= 12'h200;
      rot_case(OPC_ROT_RC, 1, 0, 8'h5f, 8'h80, 1, 12'h25f);
      rot_case(OPC_ROT_LC, 1, 0, 8'h60, 8'h01, 0, 12'hf60);
      rot_case(OPC_ROT_LP, 1, 1, 8'h10, 8'h3c, 0, 12'h310);
      finish_test();
   end
endmodule
`default_nettype wire
